// ---- pkg/latch_pkg.sv ----
// Purpose: constants and carriers for the count latch and read-back block
// Assumes: three channels, 16-bit count elements, byte-wide host port
// Notes:   host port addresses 0..2 select channels, 3 is the command word
package latch_pkg;

    localparam int          NUM_CHAN      = 3;
    localparam logic [1:0]  ADDR_CMD      = 2'h3;
    // Command word fields
    localparam int          CMD_RB_HI     = 7;
    localparam int          CMD_RB_LO     = 6;
    localparam int          CMD_CNT_N     = 5;
    localparam int          CMD_STAT_N    = 4;
    localparam int          CMD_SEL_LSB   = 1;
    localparam int          CMD_SEL_CH    = 7;
    localparam int          CMD_SEL_CL    = 6;
    localparam int          CMD_ACC_HI    = 5;
    localparam int          CMD_ACC_LO    = 4;
    // Status byte fields
    localparam int          STAT_OUT      = 7;
    localparam int          STAT_PEND     = 6;
    // Access formats, reset mode and idle read byte
    localparam logic [1:0]  ACC_LATCH     = 2'h0;
    localparam logic [1:0]  ACC_LO        = 2'h1;
    localparam logic [1:0]  ACC_HI        = 2'h2;
    localparam logic [1:0]  ACC_BOTH      = 2'h3;
    localparam logic [5:0]  MODE_RESET    = 6'h00;
    localparam logic [7:0]  RD_IDLE       = 8'h00;

    // Host port access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] addr;
        logic [7:0] wdata;
    } host_req_s;

    // Per-channel view of the counting core
    typedef struct packed {
        logic [15:0] count;
        logic        out_level;
        logic        cr_loaded;
    } chan_core_s;

endpackage

// ---- src/counter_latch_readback.sv ----
// Purpose: count/status latching and read-back for a three-channel down-counter
// Assumes: host strobes are one-cycle pulses synchronous to clk
// Notes:   counting itself lives in the counting core outside this block
`timescale 1ns/1ns

module counter_latch_readback #(
    parameter int NCH = latch_pkg::NUM_CHAN
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          nrst,
    // Host port
    input  latch_pkg::host_req_s               host,
    output logic [7:0]                         rdata,
    // Counting core
    input  latch_pkg::chan_core_s [NCH-1:0]    core,
    output logic [NCH-1:0]                     cr_written,
    output logic [NCH-1:0]                     ctrl_written
);

    //--------------------------------------------------------------
    // Channel state
    //--------------------------------------------------------------
    logic [NCH-1:0][15:0] output_latch_ff,  nxt_output_latch;
    logic [NCH-1:0]       cnt_held_ff,      nxt_cnt_held;
    logic [NCH-1:0][7:0]  stat_latch_ff,    nxt_stat_latch;
    logic [NCH-1:0]       stat_held_ff,     nxt_stat_held;
    logic [NCH-1:0][5:0]  mode_ff,          nxt_mode;
    logic [NCH-1:0]       pend_ff,          nxt_pend;
    logic [NCH-1:0]       rd_hi_ff,         nxt_rd_hi;
    logic [NCH-1:0]       wr_hi_ff,         nxt_wr_hi;
    logic [7:0]           rdata_ff,         nxt_rdata;

    logic       cmd_wr;
    logic       readback;
    logic [1:0] cmd_chan;

    assign cmd_wr   = host.wr && host.addr == latch_pkg::ADDR_CMD;
    assign readback = host.wdata[latch_pkg::CMD_RB_HI] &&
                      host.wdata[latch_pkg::CMD_RB_LO] &&
                      !host.wdata[0];
    assign cmd_chan = host.wdata[latch_pkg::CMD_SEL_CH:latch_pkg::CMD_SEL_CL];
    assign rdata    = rdata_ff;

    // Assemble the live status byte of one channel
    function automatic logic [7:0] live_status(input logic out_lvl, input logic pend,
                                               input logic [5:0] mode);
        live_status = {out_lvl, pend, mode};
    endfunction

    // Byte of a 16-bit value chosen by format and byte pointer
    function automatic logic [7:0] pick_byte(input logic [15:0] v, input logic [1:0] fmt,
                                             input logic hi);
        if (fmt == latch_pkg::ACC_HI || (fmt == latch_pkg::ACC_BOTH && hi)) begin
            pick_byte = v[15:8];
        end else begin
            pick_byte = v[7:0];
        end
    endfunction

    //--------------------------------------------------------------
    // Host strobe decode
    //--------------------------------------------------------------
    // Per-channel strobes and decodes, one bit per channel except the two-bit acc_fmt
    logic [NCH-1:0]       rd_hit;
    logic [NCH-1:0]       wr_hit;
    logic [NCH-1:0]       ctl_hit;
    logic [NCH-1:0]       cl_hit;
    logic [NCH-1:0]       rbc_hit;
    logic [NCH-1:0]       rbs_hit;
    logic [NCH-1:0][1:0]  acc_fmt;
    logic [NCH-1:0]       two_byte;
    logic [NCH-1:0]       rd_stat;
    logic [NCH-1:0]       rd_done;
    logic [NCH-1:0]       wr_done;

    // True when a two-bit port or channel field names channel idx
    function automatic logic chan_match(input logic [1:0] fld, input int idx);
        chan_match = fld == 2'(idx);
    endfunction

    always_comb begin
        rd_hit   = '0;
        wr_hit   = '0;
        ctl_hit  = '0;
        cl_hit   = '0;
        rbc_hit  = '0;
        rbs_hit  = '0;
        acc_fmt  = '0;
        two_byte = '0;
        for (int i = 0; i < NCH; i++) begin
            acc_fmt[i]  = mode_ff[i][latch_pkg::CMD_ACC_HI:latch_pkg::CMD_ACC_LO];
            two_byte[i] = acc_fmt[i] == latch_pkg::ACC_BOTH;
            rd_hit[i]   = host.rd && chan_match(host.addr, i);
            wr_hit[i]   = host.wr && chan_match(host.addr, i);
            // A read-back pattern with bit 0 set names channel 3, so nothing acts on it
            if (cmd_wr && !readback && chan_match(cmd_chan, i)) begin
                if (host.wdata[latch_pkg::CMD_ACC_HI:latch_pkg::CMD_ACC_LO]
                        == latch_pkg::ACC_LATCH) begin
                    cl_hit[i]  = 1'b1;
                end else begin
                    ctl_hit[i] = 1'b1;
                end
            end
            if (cmd_wr && readback && host.wdata[latch_pkg::CMD_SEL_LSB + i]) begin
                rbc_hit[i] = !host.wdata[latch_pkg::CMD_CNT_N];
                rbs_hit[i] = !host.wdata[latch_pkg::CMD_STAT_N];
            end
        end
    end

    assign cr_written   = wr_done;
    assign ctrl_written = ctl_hit;

    //--------------------------------------------------------------
    // Byte sequencing decode
    //--------------------------------------------------------------
    always_comb begin
        rd_stat = '0;
        rd_done = '0;
        wr_done = '0;
        for (int i = 0; i < NCH; i++) begin
            // Held status goes out before any count byte
            rd_stat[i] = rd_hit[i] && stat_held_ff[i];
            rd_done[i] = rd_hit[i] && !stat_held_ff[i] && !(two_byte[i] && !rd_hi_ff[i]);
            wr_done[i] = wr_hit[i] && !(two_byte[i] && !wr_hi_ff[i]);
        end
    end

    //--------------------------------------------------------------
    // Count latch
    //--------------------------------------------------------------
    always_comb begin
        nxt_output_latch = output_latch_ff;
        nxt_cnt_held     = cnt_held_ff;
        for (int i = 0; i < NCH; i++) begin
            if (rd_done[i]) begin
                nxt_cnt_held[i] = 1'b0;
            end
            // A held count ignores every further latch until it is read out
            if ((cl_hit[i] || rbc_hit[i]) && !cnt_held_ff[i]) begin
                nxt_output_latch[i] = core[i].count;
                nxt_cnt_held[i]     = 1'b1;
            end
            // New control word drops any held count
            if (ctl_hit[i]) begin
                nxt_cnt_held[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            output_latch_ff <= '0;
            cnt_held_ff     <= '0;
        end else begin
            output_latch_ff <= nxt_output_latch;
            cnt_held_ff     <= nxt_cnt_held;
        end
    end

    //--------------------------------------------------------------
    // Status latch
    //--------------------------------------------------------------
    always_comb begin
        nxt_stat_latch = stat_latch_ff;
        nxt_stat_held  = stat_held_ff;
        for (int i = 0; i < NCH; i++) begin
            if (rd_stat[i]) begin
                nxt_stat_held[i] = 1'b0;
            end
            // The first captured status stands until it is read
            if (rbs_hit[i] && !stat_held_ff[i]) begin
                nxt_stat_latch[i] = live_status(core[i].out_level, pend_ff[i],
                                                mode_ff[i]);
                nxt_stat_held[i]  = 1'b1;
            end
            if (ctl_hit[i]) begin
                nxt_stat_held[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            stat_latch_ff <= '0;
            stat_held_ff  <= '0;
        end else begin
            stat_latch_ff <= nxt_stat_latch;
            stat_held_ff  <= nxt_stat_held;
        end
    end

    //--------------------------------------------------------------
    // Mode and pending load
    //--------------------------------------------------------------
    always_comb begin
        nxt_mode = mode_ff;
        nxt_pend = pend_ff;
        for (int i = 0; i < NCH; i++) begin
            // Load and write in one cycle: the write wins, the new count still waits
            if (core[i].cr_loaded) begin
                nxt_pend[i] = 1'b0;
            end
            if (wr_done[i] || ctl_hit[i]) begin
                nxt_pend[i] = 1'b1;
            end
            if (ctl_hit[i]) begin
                nxt_mode[i] = host.wdata[5:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_ff <= {NCH{latch_pkg::MODE_RESET}};
            pend_ff <= '0;
        end else begin
            mode_ff <= nxt_mode;
            pend_ff <= nxt_pend;
        end
    end

    //--------------------------------------------------------------
    // Byte pointers
    //--------------------------------------------------------------
    always_comb begin
        nxt_rd_hi = rd_hi_ff;
        nxt_wr_hi = wr_hi_ff;
        for (int i = 0; i < NCH; i++) begin
            // Each pointer steps on its own strobe, so reads and writes may interleave
            if (rd_hit[i] && !stat_held_ff[i]) begin
                nxt_rd_hi[i] = two_byte[i] && !rd_hi_ff[i];
            end
            if (wr_hit[i]) begin
                nxt_wr_hi[i] = two_byte[i] && !wr_hi_ff[i];
            end
            // A control word restarts both sequences at the low byte
            if (ctl_hit[i]) begin
                nxt_rd_hi[i] = 1'b0;
                nxt_wr_hi[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rd_hi_ff <= '0;
            wr_hi_ff <= '0;
        end else begin
            rd_hi_ff <= nxt_rd_hi;
            wr_hi_ff <= nxt_wr_hi;
        end
    end

    //--------------------------------------------------------------
    // Read data
    //--------------------------------------------------------------
    always_comb begin
        nxt_rdata = rdata_ff;
        for (int i = 0; i < NCH; i++) begin
            if (rd_hit[i] && stat_held_ff[i]) begin
                nxt_rdata = stat_latch_ff[i];
            end else if (rd_hit[i] && cnt_held_ff[i]) begin
                nxt_rdata = pick_byte(output_latch_ff[i], acc_fmt[i], rd_hi_ff[i]);
            end else if (rd_hit[i]) begin
                // Unlatched reads see the live count, which may tear between bytes
                nxt_rdata = pick_byte(core[i].count, acc_fmt[i], rd_hi_ff[i]);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_ff <= latch_pkg::RD_IDLE;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

endmodule // counter_latch_readback

// ---- testbench/latch_props.sv ----
// Purpose: port-level assertions for the count latch and read-back block
// Assumes: host strobes are one-cycle pulses, 0x36 sets channel 0 two-byte mode 3
// Notes:   bound from the bench top file
`timescale 1ns/1ns
module latch_props #(
    parameter int NCH = 3
) (
    // Clock and reset
    input wire logic                          clk,
    input wire logic                          nrst,
    // Watched ports
    input latch_pkg::host_req_s               host,
    input logic [7:0]                         rdata,
    input latch_pkg::chan_core_s [NCH-1:0]    core,
    input logic [NCH-1:0]                     cr_written,
    input logic [NCH-1:0]                     ctrl_written
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_ctrl0; host.wr && host.addr == latch_pkg::ADDR_CMD && host.wdata == 8'h36; endsequence
    sequence s_wr0; host.wr && host.addr == 2'h0; endsequence
    sequence s_rd0; host.rd && host.addr == 2'h0; endsequence
    sequence s_cmd(logic [7:0] v); host.wr && host.addr == latch_pkg::ADDR_CMD && host.wdata == v;
    endsequence
    AST_RDATA_HOLD: assert property (!host.rd || host.addr == latch_pkg::ADDR_CMD |=>
        $stable(rdata)) else $error("read byte moved without a channel read");
    AST_CTRL_PULSE: assert property (host.wr && host.addr == latch_pkg::ADDR_CMD &&
        host.wdata[7:6] != 2'h3 && host.wdata[5:4] != latch_pkg::ACC_LATCH |->
        ctrl_written[host.wdata[7:6]]) else $error("control write pulse missing");
    AST_RB_NO_CTRL: assert property (s_cmd({2'h3, host.wdata[5:0]}) |->
        ctrl_written == '0) else $error("read-back taken as control word");
    AST_IDLE_QUIET: assert property (!host.wr |-> cr_written == '0 && ctrl_written == '0)
        else $error("write pulse without a write");
    AST_CR_FIRST: assert property (s_ctrl0 ##1 s_wr0 |-> !cr_written[0])
        else $error("count complete after first byte");
    AST_CR_SECOND: assert property (s_ctrl0 ##1 s_wr0 ##1 s_wr0 |-> cr_written[0])
        else $error("count not complete after second byte");
    AST_STAT_FIRST: assert property (s_ctrl0 ##1 s_cmd(8'hc2) ##1 s_rd0 |=>
        rdata == {$past(core[0].out_level, 2), 1'b1, 6'h36}) else $error("status not first");
    AST_CNT_LATCH: assert property (s_ctrl0 ##1 (s_cmd(8'hd2) or s_cmd(8'h00)) ##1 s_rd0 |=>
        rdata == $past(core[0].count[7:0], 2)) else $error("latched low byte wrong");
endmodule // latch_props

// ---- testbench/core_model.sv ----
// Purpose: counting core stand-in that feeds live counts and load pulses
// Assumes: each channel counts down every clock by its own step
// Notes:   load lands two cycles after a complete count write
`timescale 1ns/1ns
module core_model (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      nrst,
    // Block side
    input  wire logic [2:0]                cr_written,
    output latch_pkg::chan_core_s [2:0]    core
);
    logic [15:0] cnt_ff [3];
    logic [2:0]  ld_ff;
    logic [2:0]  ld2_ff;
    always_ff @(posedge clk) begin
        ld_ff  <= nrst ? cr_written : 3'h0;
        ld2_ff <= nrst ? ld_ff : 3'h0;
        for (int i = 0; i < 3; i++) cnt_ff[i] <= nrst ? cnt_ff[i] - 16'(i + 1) : 16'h1234 * 16'(i + 1);
    end
    always_comb for (int i = 0; i < 3; i++) core[i] = '{cnt_ff[i], cnt_ff[i][3], ld2_ff[i]};
endmodule // core_model

// ---- testbench/tb.sv ----
// Purpose: self-checking bench for the count latch and read-back block
// Assumes: expected bytes are queued at each read and popped when rdata settles
// Notes:   live counts move every clock, so a stale latch shows at once
`timescale 1ns/1ns
module tb;
    logic                        clk;
    logic                        nrst;
    latch_pkg::host_req_s        host;
    logic [7:0]                  rdata;
    latch_pkg::chan_core_s [2:0] core;
    logic [2:0]                  cr_written;
    logic [2:0]                  ctrl_written;
    logic [7:0]                  exp_q [$];
    logic                        rd_pend = 1'b0;
    int                          bad_count = 0;
    int                          n_tests = 0;
    int                          cyc = 0;
    logic [31:0]                 seed = 32'h93408e94;
    counter_latch_readback #(.NCH(3)) u_dut (.clk(clk), .nrst(nrst), .host(host), .rdata(rdata),
        .core(core), .cr_written(cr_written), .ctrl_written(ctrl_written));
    core_model u_core (.clk(clk), .nrst(nrst), .cr_written(cr_written), .core(core));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] e);
        n_tests++;
        if (seen !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, seen);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic put(input latch_pkg::host_req_s h);
        host = h;
        @(posedge clk);
        #1;
    endtask
    task automatic do_wr(input logic [1:0] a, input logic [7:0] d);
        put({1'b1, 1'b0, a, d});
    endtask
    task automatic do_rd(input logic [1:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        put({1'b0, 1'b1, a, 8'h00});
    endtask
    always @(posedge clk) begin
        if (rd_pend) check("read byte", rdata, exp_q.pop_front());
        rd_pend <= host.rd && host.addr != latch_pkg::ADDR_CMD;
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        logic [15:0] cc [3];
        logic [7:0]  st [3];
        logic [2:0]  sel;
        logic [31:0] r;
        host = '0;
        nrst = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        nrst = 1'b1;
        do_wr(2'h3, 8'h36);
        cc[0] = core[0].count;
        do_wr(2'h3, 8'h00);
        do_wr(2'h3, 8'h00);
        do_rd(2'h0, cc[0][7:0]);
        do_rd(2'h0, cc[0][15:8]);
        do_rd(2'h0, core[0].count[7:0]);
        $display("counter latch test done");
        do_wr(2'h3, 8'h36);
        cc[0] = core[0].count;
        do_wr(2'h3, 8'hd2);
        do_rd(2'h0, cc[0][7:0]);
        do_rd(2'h0, cc[0][15:8]);
        do_wr(2'h3, 8'h36);
        cc[0] = core[0].count;
        st[0] = {core[0].out_level, 1'b1, 6'h36};
        do_wr(2'h3, 8'hc2);
        do_rd(2'h0, st[0]);
        do_rd(2'h0, cc[0][7:0]);
        do_rd(2'h0, cc[0][15:8]);
        $display("combined latch test done");
        do_wr(2'h3, 8'h36);
        do_wr(2'h0, 8'(xs()));
        do_wr(2'h0, 8'(xs()));
        repeat (4) put('0);
        st[0] = {core[0].out_level, 1'b0, 6'h36};
        do_wr(2'h3, 8'he2);
        do_rd(2'h0, st[0]);
        $display("pending load test done");
        do_wr(2'h3, 8'h76);
        cc[1] = core[1].count;
        do_wr(2'h3, 8'h40);
        do_rd(2'h1, cc[1][7:0]);
        do_wr(2'h1, 8'h5a);
        do_rd(2'h1, cc[1][15:8]);
        do_wr(2'h1, 8'ha5);
        $display("interleave test done");
        for (int k = 0; k < 6; k++) begin
            r = xs();
            sel = (r[2:0] == 3'h0) ? 3'h5 : r[2:0];
            for (int i = 0; i < 3; i++) do_wr(2'h3, {2'(i), 2'h3, r[8+4*i +: 4]});
            for (int i = 0; i < 3; i++) cc[i] = core[i].count;
            if (r[31]) do_wr(2'h3, {4'hd, sel, 1'b0});
            for (int i = 0; i < 3; i++) st[i] = {core[i].out_level, 1'b1, 2'h3, r[8+4*i +: 4]};
            do_wr(2'h3, {r[31] ? 4'he : 4'hc, sel, 1'b0});
            do_wr(2'h3, 8'hce);
            for (int i = 0; i < 3; i++) if (sel[i]) begin
                do_rd(2'(i), st[i]);
                do_rd(2'(i), cc[i][7:0]);
                do_rd(2'(i), cc[i][15:8]);
            end
        end
        put('0);
        $display("read-back test done");
        do_wr(2'h3, 8'h40);
        nrst = 1'b0;
        repeat (2) put('0);
        check("reset read byte", rdata, latch_pkg::RD_IDLE);
        nrst = 1'b1;
        do_rd(2'h1, core[1].count[7:0]);
        put('0);
        put('0);
        $display("mid-run reset test done");
        finish_test();
    end
endmodule // tb
bind counter_latch_readback latch_props #(.NCH(NCH)) u_props (.clk(clk), .nrst(nrst),
    .host(host), .rdata(rdata), .core(core), .cr_written(cr_written), .ctrl_written(ctrl_written));
